//--- logic/dra_pkg.sv
package dra_pkg;

  // ----------------------------------------
  // Scratch RAM word locations
  // ----------------------------------------
  localparam int RAM_AW = 3;
  localparam logic [2:0] OFF_DATA_LOW = 3'h1;
  localparam logic [2:0] OFF_DATA_MID = 3'h2;
  localparam logic [2:0] OFF_DATA_HIGH = 3'h3;
  localparam logic [2:0] OFF_ADDR_CTX = 3'h4;
  localparam logic [2:0] OFF_ADDR_LOW = 3'h5;
  localparam logic [15:0] RAM_RESET = 16'h0000;

  // ----------------------------------------
  // Context word fields
  // ----------------------------------------
  localparam int CTX_SPACE_HI = 15;
  localparam int CTX_SPACE_LO = 13;
  localparam int CTX_MODE_BIT = 12;
  localparam int CTX_PROT_BIT = 11;
  localparam int CTX_ADR_HI = 5;
  localparam int DATA_HIGH_HI = 3;
  localparam logic [2:0] SPACE_EPT = 3'h0;
  localparam logic [2:0] SPACE_EVA = 3'h1;
  localparam logic [2:0] SPACE_PHYS = 3'h4;

  // ----------------------------------------
  // Buffer positions, bit 0 is the most significant
  // ----------------------------------------
  localparam int BUF_SHIFT = 16;
  localparam int BUF_CTX_POS = 30;
  localparam int BUF_ADR_POS = 14;
  localparam int ADR_BITS = 22;

  // ----------------------------------------
  // Main bus function codes
  // ----------------------------------------
  localparam logic [2:0] FN_DATAO = 3'h1;
  localparam logic [2:0] FN_DATAI = 3'h2;
  localparam logic [2:0] FN_PI_POLL = 3'h5;
  localparam logic [2:0] FN_PI_ADRIN = 3'h6;
  localparam logic [2:0] FCN_DEPOSIT = 3'h1;
  localparam logic [2:0] FCN_EXAMINE = 3'h2;
  localparam logic [6:0] DEV_CODE_DEF = 7'h20;

  // ----------------------------------------
  // Types and sequencer states
  // ----------------------------------------
  typedef logic [0:35] dra_word_t;
  typedef logic [0:6] dra_cs_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FIRST_ADDR = 4'b0010,
    ST_SECOND_ADDR = 4'b0100,
    ST_XFER = 4'b1000
  } dra_state_t;

endpackage

//--- logic/dra_ram_if.sv
`timescale 1ns/1ps
interface dra_ram_if;
  import dra_pkg::*;
  logic fe_we;
  logic [2:0] fe_addr;
  logic [15:0] fe_wdata;
  logic [15:0] rd_data;
  logic ex_we;
  dra_word_t ex_data;
  logic [15:0] w_low;
  logic [15:0] w_mid;
  logic [15:0] w_high;
  logic [15:0] w_ctx;
  logic [15:0] w_adr;

  modport asm (output fe_we, fe_addr, fe_wdata, ex_we, ex_data,
    input rd_data, w_low, w_mid, w_high, w_ctx, w_adr);
  modport ram (input fe_we, fe_addr, fe_wdata, ex_we, ex_data,
    output rd_data, w_low, w_mid, w_high, w_ctx, w_adr);
endinterface

//--- logic/dra_scratch_ram.sv
`timescale 1ns/1ps
module dra_scratch_ram (
  input wire logic mclk,
  input wire logic rst,
  dra_ram_if.ram bus
);
  import dra_pkg::*;

  localparam int DEPTH = 1 << RAM_AW;

  logic [15:0] mem_reg [DEPTH];
  logic [15:0] ex_word [DEPTH];
  logic [DEPTH-1:0] ex_hit;

  // ----------------------------------------
  // Storage, front-end write beats examine load
  // ----------------------------------------
  assign ex_word[OFF_DATA_LOW] = bus.ex_data[20:35];
  assign ex_word[OFF_DATA_MID] = bus.ex_data[4:19];
  assign ex_word[OFF_DATA_HIGH] = {12'h000, bus.ex_data[0:3]};

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_word
      if (i < OFF_DATA_LOW || i > OFF_DATA_HIGH) begin : g_nx
        assign ex_hit[i] = 1'b0;
        if (i != OFF_DATA_LOW) begin : g_z
          assign ex_word[i] = 16'h0000;
        end
      end else begin : g_x
        assign ex_hit[i] = bus.ex_we;
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          mem_reg[i] <= RAM_RESET;
        end else if (bus.fe_we && bus.fe_addr == RAM_AW'(i)) begin
          mem_reg[i] <= bus.fe_wdata;
        end else if (ex_hit[i]) begin
          mem_reg[i] <= ex_word[i];
        end
      end
    end
  endgenerate

  assign bus.rd_data = mem_reg[bus.fe_addr];
  assign bus.w_low = mem_reg[OFF_DATA_LOW];
  assign bus.w_mid = mem_reg[OFF_DATA_MID];
  assign bus.w_high = mem_reg[OFF_DATA_HIGH];
  assign bus.w_ctx = mem_reg[OFF_ADDR_CTX];
  assign bus.w_adr = mem_reg[OFF_ADDR_LOW];

endmodule

//--- logic/dra_deposit_assembler.sv
`timescale 1ns/1ps
// Functional notes
// - Context bit 12 selects deposit or examine
// - Context bit 11 requests unprotected access
// - Context bits 15-13 pick address space
// - Address word gives address bits 20-35
// - High data word bits 3-0 give 0-3
// - Middle gives 4-19, low gives 20-35
// - Data word writes never start sequence
// - Address-low write starts sequence only when idle
// - Context write copies mode into flag
// - Sequence steps through four one-hot time states
// - First state loads context into buffer
// - Second state shifts, loads, forms address
// - Assembled address raises transfer request
// - Hold second state until function taken
// - Poll answer: number on its bit
// - Selection answer: function word, ack, transfer
module dra_deposit_assembler #(
  parameter int PHYS_NUM = 0,
  parameter int PI_CHAN = 1,
  parameter logic [6:0] DEV_CODE = dra_pkg::DEV_CODE_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic fe_wr_en,
  input wire logic fe_rd_en,
  input wire logic [2:0] fe_addr,
  input wire logic [15:0] fe_wdata,
  output logic [15:0] fe_rdata,
  output logic fe_rd_valid,
  input wire logic mb_demand,
  input wire dra_pkg::dra_cs_t mb_cs,
  input wire logic [2:0] mb_func,
  input wire dra_pkg::dra_word_t mb_data_in,
  output dra_pkg::dra_word_t mb_data_out,
  output logic mb_data_oe,
  output logic select_a,
  output logic mb_transfer,
  output logic transfer_request,
  output logic busy,
  output logic deposit_mode,
  output logic space_error
);
  import dra_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (PHYS_NUM < 0 || PHYS_NUM > 15) begin : g_bad_phys
      $error("PHYS_NUM must fit the 4-bit select field");
    end
    if (PI_CHAN < 0 || PI_CHAN > 7) begin : g_bad_chan
      $error("PI_CHAN must fit the 3-bit channel field");
    end
  endgenerate

  localparam logic [3:0] PHYS_SEL = 4'(PHYS_NUM);
  localparam logic [2:0] CHAN_SEL = 3'(PI_CHAN);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  dra_ram_if ram ();

  dra_state_t state_reg;
  dra_state_t state_next;
  dra_word_t buf_reg;
  dra_word_t buf_next;
  logic shifted_reg;
  logic shifted_next;
  logic req_reg;
  logic req_next;
  logic dep_flag_reg;
  logic dep_flag_next;
  logic space_err_reg;
  logic space_err_next;
  logic prot_reg;
  logic prot_next;
  logic [2:0] space_reg;
  logic [2:0] space_next;
  logic busy_reg;
  logic dem_q_reg;
  logic [15:0] fe_rdata_reg;
  logic fe_rd_valid_reg;
  dra_word_t mb_data_reg;
  dra_word_t mb_data_next;
  logic mb_oe_reg;
  logic ack_reg;
  logic xfer_reg;

  logic wr_ctx;
  logic wr_adr;
  logic in_range;
  logic new_demand;
  logic chan_match;
  logic poll_hit;
  logic sel_hit;
  logic dati_hit;
  logic dato_hit;
  logic fcn_taken;
  logic xfer_done;
  logic unprot;
  logic [2:0] space_code;
  logic space_ok;
  dra_word_t data_word;
  dra_word_t fcn_word;
  dra_word_t poll_word;
  dra_word_t buf_first;
  dra_word_t buf_second;
  logic [2:0] fcn_code;
  logic ans_hold;
  logic ack_next;
  logic mb_oe_next;

  // ----------------------------------------
  // Scratch RAM
  // ----------------------------------------
  dra_scratch_ram u_ram (
    .mclk(mclk),
    .rst(rst),
    .bus(ram.ram)
  );

  assign in_range = fe_addr >= OFF_DATA_LOW && fe_addr <= OFF_ADDR_LOW;
  assign ram.fe_we = fe_wr_en && in_range;
  assign ram.fe_addr = fe_addr;
  assign ram.fe_wdata = fe_wdata;
  assign ram.ex_we = dato_hit && new_demand;
  assign ram.ex_data = mb_data_in;

  // ----------------------------------------
  // Front-end write decode
  // ----------------------------------------
  assign wr_ctx = fe_wr_en && fe_addr == OFF_ADDR_CTX;
  // Data locations take no part in starting
  assign wr_adr = fe_wr_en && fe_addr == OFF_ADDR_LOW;

  // Mode flag follows the context write
  assign dep_flag_next = wr_ctx ? fe_wdata[CTX_MODE_BIT]
                                : dep_flag_reg;

  // ----------------------------------------
  // Context checks
  // ----------------------------------------
  assign unprot = ram.w_ctx[CTX_PROT_BIT];
  assign space_code = ram.w_ctx[CTX_SPACE_HI:CTX_SPACE_LO];
  assign space_ok = space_code == SPACE_EPT || space_code == SPACE_EVA
                 || space_code == SPACE_PHYS;

  // ----------------------------------------
  // Data word assembly
  // ----------------------------------------
  assign data_word = {ram.w_high[DATA_HIGH_HI:0],
                      ram.w_mid, ram.w_low};

  // ----------------------------------------
  // Address buffer assembly
  // ----------------------------------------
  always_comb begin
    buf_first = '0;
    buf_first[BUF_CTX_POS:35] = ram.w_ctx[CTX_ADR_HI:0];
  end

  // Shift left and drop address-low into the freed slot
  assign buf_second = {buf_reg[BUF_SHIFT:35], ram.w_adr};

  // ----------------------------------------
  // Service function word
  // ----------------------------------------
  assign fcn_code = dep_flag_reg ? FCN_DEPOSIT : FCN_EXAMINE;
  assign fcn_word = {fcn_code, prot_reg, space_reg, 7'h00,
                     buf_reg[BUF_ADR_POS:35]};

  always_comb begin
    poll_word = '0;
    poll_word[PHYS_NUM] = 1'b1;
  end

  // ----------------------------------------
  // Main bus decode
  // ----------------------------------------
  assign new_demand = mb_demand && !dem_q_reg;
  assign chan_match = mb_cs[4:6] == CHAN_SEL;
  assign poll_hit = mb_demand && mb_func == FN_PI_POLL
                 && chan_match && req_reg;
  assign sel_hit = mb_demand && mb_func == FN_PI_ADRIN && chan_match
                && mb_cs[0:3] == PHYS_SEL && req_reg;
  assign dati_hit = mb_demand && mb_func == FN_DATAI
                 && mb_cs == DEV_CODE && state_reg == ST_XFER
                 && dep_flag_reg;
  assign dato_hit = mb_demand && mb_func == FN_DATAO
                 && mb_cs == DEV_CODE && state_reg == ST_XFER
                 && !dep_flag_reg;
  assign fcn_taken = sel_hit && new_demand;
  assign xfer_done = (dati_hit || dato_hit) && new_demand;
  // Answers stand until the demand drops
  assign ans_hold = mb_demand && ack_reg;
  assign ack_next = sel_hit || dati_hit || dato_hit || ans_hold;
  assign mb_oe_next = poll_hit || sel_hit || dati_hit
                   || (ans_hold && mb_oe_reg);

  always_comb begin
    if (sel_hit) begin
      mb_data_next = fcn_word;
    end else if (dati_hit) begin
      mb_data_next = data_word;
    end else if (poll_hit) begin
      mb_data_next = poll_word;
    end else if (ans_hold) begin
      mb_data_next = mb_data_reg;
    end else begin
      mb_data_next = '0;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    buf_next = buf_reg;
    shifted_next = shifted_reg;
    req_next = req_reg;
    space_err_next = space_err_reg;
    prot_next = prot_reg;
    space_next = space_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (wr_adr) begin
          state_next = ST_FIRST_ADDR;
          space_err_next = 1'b0;
        end
      end
      ST_FIRST_ADDR: begin
        buf_next = buf_first;
        prot_next = unprot;
        space_next = space_code;
        shifted_next = 1'b0;
        if (unprot && !space_ok) begin
          space_err_next = 1'b1;
        end
        state_next = ST_SECOND_ADDR;
      end
      ST_SECOND_ADDR: begin
        if (!shifted_reg) begin
          buf_next = buf_second;
          shifted_next = 1'b1;
          req_next = 1'b1;
        end else if (fcn_taken) begin
          req_next = 1'b0;
          state_next = ST_XFER;
        end
      end
      ST_XFER: begin
        if (xfer_done) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      buf_reg <= '0;
      shifted_reg <= 1'b0;
      req_reg <= 1'b0;
      space_err_reg <= 1'b0;
      prot_reg <= 1'b0;
      space_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      buf_reg <= buf_next;
      shifted_reg <= shifted_next;
      req_reg <= req_next;
      space_err_reg <= space_err_next;
      prot_reg <= prot_next;
      space_reg <= space_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dep_flag_reg <= 1'b0;
      busy_reg <= 1'b0;
      dem_q_reg <= 1'b0;
    end else begin
      dep_flag_reg <= dep_flag_next;
      busy_reg <= state_next != ST_IDLE;
      dem_q_reg <= mb_demand;
    end
  end

  // ----------------------------------------
  // Main bus answers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      mb_data_reg <= '0;
      mb_oe_reg <= 1'b0;
      ack_reg <= 1'b0;
      xfer_reg <= 1'b0;
    end else begin
      mb_data_reg <= mb_data_next;
      mb_oe_reg <= mb_oe_next;
      ack_reg <= ack_next;
      xfer_reg <= ack_next;
    end
  end

  // ----------------------------------------
  // Front-end read port
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      fe_rdata_reg <= 16'h0000;
      fe_rd_valid_reg <= 1'b0;
    end else begin
      fe_rdata_reg <= (fe_rd_en && in_range) ? ram.rd_data : 16'h0000;
      fe_rd_valid_reg <= fe_rd_en;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign fe_rdata = fe_rdata_reg;
  assign fe_rd_valid = fe_rd_valid_reg;
  assign mb_data_out = mb_data_reg;
  assign mb_data_oe = mb_oe_reg;
  assign select_a = ack_reg;
  assign mb_transfer = xfer_reg;
  assign transfer_request = req_reg;
  assign busy = busy_reg;
  assign deposit_mode = dep_flag_reg;
  assign space_error = space_err_reg;

endmodule

//--- test/dra_deposit_assembler_properties.sv
`timescale 1ns/1ps
// ---------------------------
// Port checks
// ---------------------------
module dra_props #(
  parameter int PHYS_NUM = 0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic fe_wr_en,
  input wire logic [2:0] fe_addr,
  input wire logic [15:0] fe_wdata,
  input wire logic mb_demand,
  input wire logic [2:0] mb_func,
  input wire dra_pkg::dra_word_t mb_data_out,
  input wire logic mb_data_oe,
  input wire logic select_a,
  input wire logic mb_transfer,
  input wire logic transfer_request,
  input wire logic busy,
  input wire logic deposit_mode
);
  import dra_pkg::*;
  logic mode_in;
  assign mode_in = fe_wdata[CTX_MODE_BIT];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  start_seq_a: assert property (
    fe_wr_en && fe_addr == OFF_ADDR_LOW && !busy |=> busy)
    else $error("no start");
  data_nostart_a: assert property (
    fe_wr_en && fe_addr inside {[1:3]} && !busy |=> !busy)
    else $error("data write started");
  req_timing_a: assert property (
    $rose(busy) |-> !transfer_request ##2 transfer_request)
    else $error("request timing");
  req_hold_a: assert property (
    $fell(transfer_request) |-> $rose(select_a) && busy)
    else $error("request dropped early");
  req_busy_a: assert property (transfer_request |-> busy)
    else $error("request while idle");
  poll_word_a: assert property (
    $rose(mb_data_oe) && !select_a |->
    mb_data_out == dra_word_t'(36'h800000000 >> PHYS_NUM))
    else $error("poll word");
  fcn_word_a: assert property (
    $rose(select_a) && $past(mb_func) == FN_PI_ADRIN |->
    mb_transfer && mb_data_oe &&
    mb_data_out[0:2] == (deposit_mode ? FCN_DEPOSIT : FCN_EXAMINE))
    else $error("function word");
  mode_flag_a: assert property (
    fe_wr_en && fe_addr == OFF_ADDR_CTX |=> deposit_mode == $past(mode_in))
    else $error("mode flag");
  demand_drop_a: assert property (
    $fell(mb_demand) |=> !select_a && !mb_data_oe)
    else $error("no release");
  ack_hold_a: assert property (
    select_a && mb_demand |=> select_a)
    else $error("select_a dropped");
  cover property ($rose(transfer_request));
  cover property ($rose(select_a) && deposit_mode);
  cover property ($rose(select_a) && !deposit_mode);
endmodule

bind dra_deposit_assembler dra_props #(.PHYS_NUM(PHYS_NUM)) u_props (
  .mclk(mclk), .rst(rst), .fe_wr_en(fe_wr_en), .fe_addr(fe_addr),
  .fe_wdata(fe_wdata), .mb_demand(mb_demand), .mb_func(mb_func),
  .mb_data_out(mb_data_out), .mb_data_oe(mb_data_oe),
  .select_a(select_a), .mb_transfer(mb_transfer),
  .transfer_request(transfer_request), .busy(busy),
  .deposit_mode(deposit_mode));

//--- test/dra_cpu_model.sv
`timescale 1ns/1ps
// ---------------------------
// Main processor side
// ---------------------------
module dra_cpu_model #(
  parameter int PHYS_NUM = 0,
  parameter int PI_CHAN = 1,
  parameter logic [6:0] DEV_CODE = dra_pkg::DEV_CODE_DEF
) (
  input wire logic mclk,
  input wire logic [3:0] gap,
  input wire dra_pkg::dra_word_t ex_data,
  input wire logic transfer_request,
  input wire logic select_a,
  input wire logic mb_data_oe,
  input wire dra_pkg::dra_word_t mb_data_out,
  output logic mb_demand,
  output dra_pkg::dra_cs_t mb_cs,
  output logic [2:0] mb_func,
  output dra_pkg::dra_word_t mb_data_in,
  output dra_pkg::dra_word_t poll_w,
  output dra_pkg::dra_word_t fcn_w,
  output dra_pkg::dra_word_t data_w,
  output logic [7:0] done_cnt
);
  import dra_pkg::*;
  task automatic xact(input logic [2:0] f, input dra_cs_t cs,
    input dra_word_t d, output dra_word_t got);
    int n;
    repeat (gap) @(negedge mclk);
    @(negedge mclk);
    mb_func = f;
    mb_cs = cs;
    mb_data_in = d;
    mb_demand = 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(mb_data_oe || select_a) && n < 8);
    got = (mb_data_oe || select_a) ? mb_data_out : 'x;
    @(negedge mclk);
    mb_demand = 1'h0;
    mb_data_in = ~d;
  endtask

  initial begin
    mb_demand = 1'h0;
    mb_cs = '0;
    mb_func = '0;
    mb_data_in = '0;
    done_cnt = '0;
    forever begin
      @(posedge mclk);
      if (transfer_request === 1'h1) begin
        xact(FN_PI_POLL, {4'h0, 3'(PI_CHAN)}, '0, poll_w);
        xact(FN_PI_ADRIN, {4'(PHYS_NUM), 3'(PI_CHAN)}, '0, fcn_w);
        if (fcn_w[0:2] === FCN_DEPOSIT)
          xact(FN_DATAI, DEV_CODE, '0, data_w);
        else
          xact(FN_DATAO, DEV_CODE, ex_data, data_w);
        done_cnt++;
      end
    end
  end
endmodule

//--- test/dra_deposit_assembler_tb.sv
`timescale 1ns/1ps
// ---------------------------
// Deposit sequence bench
// ---------------------------
module dra_deposit_assembler_tb;
  import dra_pkg::*;
  localparam int PN = 3;
  localparam int CH = 5;
  logic mclk, rst, fe_wr_en, fe_rd_en, fe_rd_valid, mb_demand, mb_data_oe;
  logic select_a, mb_transfer, transfer_request, busy, deposit_mode;
  logic space_error;
  logic [2:0] fe_addr, mb_func;
  logic [15:0] fe_wdata, fe_rdata;
  dra_cs_t mb_cs;
  dra_word_t mb_data_in, mb_data_out, ex_data, poll_w, fcn_w, data_w;
  logic [3:0] gap;
  logic [7:0] done_cnt;
  logic [31:0] seed = 32'h61fe;
  int miscompares = 0;
  int n_checks = 0;

  dra_deposit_assembler #(.PHYS_NUM(PN), .PI_CHAN(CH)) dut (
    .mclk(mclk), .rst(rst), .fe_wr_en(fe_wr_en), .fe_rd_en(fe_rd_en),
    .fe_addr(fe_addr), .fe_wdata(fe_wdata), .fe_rdata(fe_rdata),
    .fe_rd_valid(fe_rd_valid), .mb_demand(mb_demand), .mb_cs(mb_cs),
    .mb_func(mb_func), .mb_data_in(mb_data_in),
    .mb_data_out(mb_data_out), .mb_data_oe(mb_data_oe),
    .select_a(select_a), .mb_transfer(mb_transfer),
    .transfer_request(transfer_request), .busy(busy),
    .deposit_mode(deposit_mode), .space_error(space_error));
  dra_cpu_model #(.PHYS_NUM(PN), .PI_CHAN(CH)) cpu (
    .mclk(mclk), .gap(gap), .ex_data(ex_data),
    .transfer_request(transfer_request), .select_a(select_a),
    .mb_data_oe(mb_data_oe), .mb_data_out(mb_data_out),
    .mb_demand(mb_demand), .mb_cs(mb_cs), .mb_func(mb_func),
    .mb_data_in(mb_data_in), .poll_w(poll_w), .fcn_w(fcn_w),
    .data_w(data_w), .done_cnt(done_cnt));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic dra_word_t fcn_of(logic [15:0] c, logic [15:0] a);
    dra_word_t w;
    w = '0;
    w[0:2] = c[12] ? FCN_DEPOSIT : FCN_EXAMINE;
    w[3] = c[11];
    w[4:6] = c[15:13];
    w[14:35] = {c[5:0], a};
    return w;
  endfunction

  task automatic chk(string nm, dra_word_t e, dra_word_t g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(logic [2:0] a, logic [15:0] d);
    @(negedge mclk);
    fe_addr = a;
    fe_wdata = d;
    fe_wr_en = 1'h1;
    @(negedge mclk);
    fe_wr_en = 1'h0;
  endtask

  task automatic rd(logic [2:0] a, logic [15:0] e);
    @(negedge mclk);
    fe_addr = a;
    fe_rd_en = 1'h1;
    @(negedge mclk);
    fe_rd_en = 1'h0;
    chk("rd_valid", 1'h1, fe_rd_valid);
    chk("rdata", e, fe_rdata);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #100000;
    miscompares++;
    close_out();
  end

  initial begin
    logic [15:0] lo, mi, hi, ctx, adr;
    logic [7:0] d0;
    logic [2:0] sp [3];
    int k;
    sp = '{SPACE_EPT, SPACE_EVA, SPACE_PHYS};
    rst = 1'h1;
    fe_wr_en = 1'h0;
    fe_rd_en = 1'h0;
    fe_addr = '0;
    fe_wdata = '0;
    gap = '0;
    ex_data = '0;
    repeat (12) @(negedge mclk);
    rst = 1'h0;
    for (int a = 0; a < 8; a++)
      rd(3'(a), RAM_RESET);
    wr(3'h7, 16'hbeef);
    rd(3'h7, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      lo = 16'(rnd());
      mi = 16'(rnd());
      hi = 16'(rnd());
      adr = (i == 0) ? 16'hffff : 16'(rnd());
      if (i == 0)
        hi[15:4] = '1;
      ctx = 16'(rnd());
      ctx[15:13] = sp[rnd() % 3];
      ctx[12] = ~i[0];
      gap = (i == 0) ? 4'h0 : 4'(rnd() % 6);
      ex_data = dra_word_t'({rnd(), rnd()});
      wr(OFF_DATA_LOW, lo);
      wr(OFF_DATA_MID, mi);
      wr(OFF_DATA_HIGH, hi);
      chk("busy", 1'h0, busy);
      wr(OFF_ADDR_CTX, ctx);
      chk("mode", ctx[12], deposit_mode);
      d0 = done_cnt;
      wr(OFF_ADDR_LOW, adr);
      chk("busy", 1'h1, busy);
      if (i == 2) begin
        repeat (4) @(negedge mclk);
        wr(OFF_ADDR_LOW, ~adr);
        rd(OFF_ADDR_LOW, ~adr);
      end
      k = 0;
      while (done_cnt == d0 && k < 300) begin
        @(negedge mclk);
        k++;
      end
      chk("done", 1'h1, done_cnt != d0);
      chk("poll", dra_word_t'(36'h800000000 >> PN), poll_w);
      chk("fcn", fcn_of(ctx, adr), fcn_w);
      if (ctx[12])
        chk("data", {hi[3:0], mi, lo}, data_w);
      else begin
        rd(OFF_DATA_LOW, ex_data[20:35]);
        rd(OFF_DATA_MID, ex_data[4:19]);
        rd(OFF_DATA_HIGH, {12'h000, ex_data[0:3]});
      end
      repeat (3) @(negedge mclk);
      chk("idle", 1'h0, busy);
      $display("test %0d done", i);
    end
    chk("space_err", 1'h0, space_error);
    close_out();
  end
endmodule
